//--- hdl/spr_pkg.sv
/*
  spr_pkg: shared constants and types for the pattern recognizer, fill-threshold
  flag and pin routing block.
  assumes: a single 100 MHz clock and a classic Wishbone register port.
*/
package spr_pkg;

  // ----------------------------------------------------------------
  // register map (word byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PATTERN_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PATTERN_LO     = 8'h04;
  localparam logic [7:0] ADDR_PATTERN_HI     = 8'h08;
  localparam logic [7:0] ADDR_FILL_THRESHOLD = 8'h0c;
  localparam logic [7:0] ADDR_PIN_ROUTE_A    = 8'h10;
  localparam logic [7:0] ADDR_PIN_ROUTE_B    = 8'h14;
  localparam logic [7:0] ADDR_CHIP_MODE      = 8'h18;
  localparam logic [7:0] ADDR_STATUS         = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_SYNC_EN_BIT   = 4;  // sync_detect_enable
  localparam int CFG_LEN_LSB       = 0;  // pattern_length_field, 3 bits, bytes-1
  localparam int MODE_LSB          = 0;  // chip mode, 3 bits
  localparam int MODE_PACKET_BIT   = 3;  // 1 = packet data mode
  localparam int MODE_BITSYNC_BIT  = 4;  // host bit synchronizer enable
  localparam int MODE_RC_BIT       = 5;  // rc oscillator running

  // status / irq bit positions
  localparam int ST_MATCH  = 0;
  localparam int ST_LEVEL  = 1;
  localparam int ST_EMPTY  = 2;
  localparam int ST_FULL   = 3;
  localparam int IRQ_W     = 4;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH  = 64;
  localparam int PATTERN_BITS = 64;
  localparam int PIN_COUNT    = 6;
  localparam logic [31:0] RST_PATTERN_LO = 32'h0101_0101;
  localparam logic [31:0] RST_PATTERN_HI = 32'h0101_0101;
  localparam logic [5:0]  RST_THRESHOLD  = 6'h0f;
  localparam logic [2:0]  RST_LENGTH     = 3'h3;

  // chip modes
  typedef enum logic [2:0] {
    MODE_SLEEP, MODE_STANDBY, MODE_SYNTH, MODE_RX, MODE_TX
  } spr_mode_e;

  // chip-side event inputs grouped together
  typedef struct packed {
    logic payload_ready;
    logic frame_sent;
    logic checksum_pass;
    logic transmit_ready;
    logic mode_settled;
    logic reference_clock;
  } spr_events_s;

  // byte stream push/pop from the chip data path
  typedef struct packed {
    logic push;
    logic pop;
  } spr_queue_op_s;

endpackage

//--- hdl/spr_top.sv
/*
  spr_top: serial pattern recognizer, fill-threshold flag for a 64-byte byte
  queue, and six general outputs (routed on pins 0, 1, 2 and 5; pins 3 and 4 held low), behind a classic Wishbone slave.
  assumes: all inputs except bit_data_i/bit_valid_i/bit_clock_i come from logic on clk_i;
  the demodulated bit stream arrives from the pin side and is synchronised here.
*/
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module spr_top #(
  parameter int DEPTH = spr_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  output logic                    irq_o,
  // demodulated bit stream from the pin side
  input  wire logic               bit_data_i,
  input  wire logic               bit_valid_i,
  input  wire logic               bit_clock_i,
  // queue operations and chip events
  input  wire spr_pkg::spr_queue_op_s queue_op_i,
  input  wire spr_pkg::spr_events_s   events_i,
  // routed pins and status
  output logic [spr_pkg::PIN_COUNT-1:0] general_io_o,
  output logic                    bit_sync_on_o
);
  import spr_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]            sync0;     // first stage, read only by sync1
    logic [2:0]            sync1;
    logic                  valid_prev;
    logic [PATTERN_BITS-1:0] shift;
    logic [6:0]            fill_bits; // received bits since enable
    logic [31:0]           pat_lo;
    logic [31:0]           pat_hi;
    logic                  sync_en;
    logic [2:0]            length;
    logic [5:0]            threshold;
    logic [11:0]           routes;
    logic [2:0]            mode;
    logic [2:0]            prev_mode;
    logic                  packet;
    logic                  bitsync;
    logic                  rc_on;
    logic [CW-1:0]         count;
    logic                  level;
    logic                  full_seen;
    logic                  match;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_mask;
    logic [31:0]           rdata;
    logic                  ack;
    logic                  irq;
    logic [PIN_COUNT-1:0]  pins;
    logic                  bitsync_out;
    logic                  fresh;     // a bit went into the window last cycle
  } spr_state_s;

  spr_state_s s_q, s_d;

  logic [PATTERN_BITS-1:0] pattern;
  logic [PATTERN_BITS-1:0] cmp_mask;
  logic                    hit;
  logic                    q_empty;
  logic                    q_full;
  logic                    wb_req;
  logic [IRQ_W-1:0]        events;
  logic                    bit_clk_s;
  logic                    bit_dat_s;

  assign pattern  = {s_q.pat_hi, s_q.pat_lo};
  assign q_empty  = (s_q.count == '0);
  assign q_full   = (s_q.count == CW'(DEPTH));
  assign wb_req   = cyc_i & stb_i & ~s_q.ack;
  assign bit_dat_s = s_q.sync1[0];
  assign bit_clk_s = s_q.sync1[2];

  // ----------------------------------------------------------------
  // pattern comparison
  // ----------------------------------------------------------------
  // the pattern sits left-aligned: bit 63 is the first byte's MSB, so a
  // shorter length keeps the first bytes and drops the trailing ones.
  // the newest received bit is shift[0], so the pattern is shifted down to meet it.
  always_comb begin
    logic [PATTERN_BITS-1:0] aligned;
    aligned  = '0;
    cmp_mask = '0;
    for (int i = 0; i < PATTERN_BITS; i++) begin
      if (i < (int'(s_q.length) + 1) * 8) begin
        cmp_mask[i] = 1'b1;
      end
    end
    // earliest bit against MSB of first byte, latest against LSB of last
    aligned = pattern >> (PATTERN_BITS - (int'(s_q.length) + 1) * 8);
    hit = (((s_q.shift ^ aligned) & cmp_mask) == '0)
        && (int'(s_q.fill_bits) >= (int'(s_q.length) + 1) * 8);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic new_bit;
    logic in_rx;
    logic push_ok;
    logic pop_ok;
    logic [CW-1:0] cnt_n;
    logic [1:0] code;
    logic [IRQ_W-1:0] clr;
    new_bit = 1'b0;
    in_rx   = 1'b0;
    push_ok = 1'b0;
    pop_ok  = 1'b0;
    cnt_n   = '0;
    code    = '0;
    clr     = '0;
    s_d     = s_q;

    // two-flop capture of the pin-side stream
    // only sync1 reads sync0, so a metastable first stage never reaches logic
    s_d.sync0 = {bit_clock_i, bit_valid_i, bit_data_i};
    s_d.sync1 = s_q.sync0;
    s_d.valid_prev = s_q.sync1[1];
    new_bit = s_q.sync1[1] & ~s_q.valid_prev;
    in_rx   = (s_q.mode == 3'(MODE_RX));

    // bit synchronizer: forced in packet mode, host-driven in continuous
    s_d.bitsync_out = s_q.packet | s_q.bitsync;

    // the window is compared in the cycle after the shift, so the bit just
    // taken is part of it; comparing before the shift would lag one bit
    s_d.fresh = 1'b0;
    // shift register of received bits, only while recognition is on
    if (!s_q.sync_en || !in_rx || !s_q.bitsync_out) begin
      s_d.fill_bits = '0;
    end else if (new_bit) begin
      s_d.shift = {s_q.shift[PATTERN_BITS-2:0], bit_dat_s};
      s_d.fresh = 1'b1;
      if (s_q.fill_bits != 7'h40) begin
        s_d.fill_bits = s_q.fill_bits + 7'h01;
      end
    end

    // queue byte count; mode changes never clear it
    // a push and a pop together leave the count alone unless it is 0 or DEPTH; a push into a full
    // queue or a pop from an empty one is dropped rather than wrapping
    push_ok = queue_op_i.push & ~q_full;
    pop_ok  = queue_op_i.pop & ~q_empty;
    cnt_n   = s_q.count;
    if (push_ok && !pop_ok) begin
      cnt_n = s_q.count + CW'(1);
    end else if (pop_ok && !push_ok) begin
      cnt_n = s_q.count - CW'(1);
    end
    s_d.count = cnt_n;

    // threshold flag only moves on a read or write
    // while full_seen is set the flag keeps its last value until the queue empties; software ignores it
    if (queue_op_i.push || queue_op_i.pop) begin
      if (cnt_n == CW'(DEPTH)) begin
        s_d.full_seen = 1'b1;
      end else if (cnt_n == '0) begin
        s_d.full_seen = 1'b0;
      end
      if (!s_q.full_seen || cnt_n == '0) begin
        s_d.level = (cnt_n > CW'(s_q.threshold));
      end
    end

    // match flag: set by hit, cleared when leaving rx or queue empties
    // a hit counts only on a freshly shifted window; leaving receive is seen
    // one cycle late via prev_mode, harmless as no bit is taken outside rx
    s_d.prev_mode = s_q.mode;
    if (s_q.sync_en && in_rx && s_q.bitsync_out && s_q.fresh && hit) begin
      s_d.match = 1'b1;
    end else if ((s_q.prev_mode == 3'(MODE_RX) && !in_rx)
              || (pop_ok && cnt_n == '0)) begin
      s_d.match = 1'b0;
    end

    // wishbone writes
    // ack drops for a cycle after each answer, so a held strobe is not taken twice
    s_d.ack = wb_req;
    if (wb_req && we_i && sel_i[0]) begin
      case (adr_i)
        ADDR_PATTERN_CONFIG: begin
          s_d.sync_en = dat_i[CFG_SYNC_EN_BIT];
          s_d.length  = dat_i[CFG_LEN_LSB +: 3];
        end
        ADDR_PATTERN_LO:     s_d.pat_lo = dat_i;
        ADDR_PATTERN_HI:     s_d.pat_hi = dat_i;
        ADDR_FILL_THRESHOLD: s_d.threshold = dat_i[5:0];
        ADDR_PIN_ROUTE_A:    s_d.routes[7:0] = dat_i[7:0];
        ADDR_PIN_ROUTE_B:    s_d.routes[11:8] = dat_i[3:0];
        ADDR_CHIP_MODE: begin
          s_d.mode    = dat_i[MODE_LSB +: 3];
          s_d.packet  = dat_i[MODE_PACKET_BIT];
          s_d.bitsync = dat_i[MODE_BITSYNC_BIT];
          s_d.rc_on   = dat_i[MODE_RC_BIT];
        end
        ADDR_IRQ_STATUS:     clr = dat_i[IRQ_W-1:0];
        ADDR_IRQ_MASK:       s_d.irq_mask = dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end

    // sticky status; a new event wins over a clear in the same cycle
    events = {s_d.full_seen & ~s_q.full_seen, q_empty, s_d.level & ~s_q.level,
              s_d.match & ~s_q.match};
    events[ST_EMPTY] = pop_ok && cnt_n == '0;
    s_d.irq_stat = (s_q.irq_stat & ~clr) | events;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // wishbone reads; unmapped addresses read zero
    s_d.rdata = '0;
    if (wb_req && !we_i) begin
      case (adr_i)
        ADDR_PATTERN_CONFIG: s_d.rdata = 32'({s_q.sync_en, 1'b0, s_q.length});
        ADDR_PATTERN_LO:     s_d.rdata = s_q.pat_lo;
        ADDR_PATTERN_HI:     s_d.rdata = s_q.pat_hi;
        ADDR_FILL_THRESHOLD: s_d.rdata = 32'(s_q.threshold);
        ADDR_PIN_ROUTE_A:    s_d.rdata = 32'(s_q.routes[7:0]);
        ADDR_PIN_ROUTE_B:    s_d.rdata = 32'(s_q.routes[11:8]);
        ADDR_CHIP_MODE:      s_d.rdata = 32'({s_q.rc_on, s_q.bitsync, s_q.packet, s_q.mode});
        ADDR_STATUS:         s_d.rdata = 32'({q_full, q_empty, s_q.level, s_q.match})
                                       | (32'(s_q.count) << 8);
        ADDR_IRQ_STATUS:     s_d.rdata = 32'(s_q.irq_stat);
        ADDR_IRQ_MASK:       s_d.rdata = 32'(s_q.irq_mask);
        default:             s_d.rdata = '0;
      endcase
    end

    // pin routing, one 2-bit code per pin
    // codes with no routed signal drive the pin low
    s_d.pins = '0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      code = s_q.routes[p*2 +: 2];
      case (p)
        0: begin
          if (s_q.packet) begin
            if (code == 2'h0) begin
              s_d.pins[p] = in_rx ? events_i.payload_ready :
                            (s_q.mode == 3'(MODE_TX)) & events_i.frame_sent;
            end else if (code == 2'h1) begin
              s_d.pins[p] = in_rx & events_i.checksum_pass;
            end
          end else if (code == 2'h0) begin
            s_d.pins[p] = in_rx ? s_q.match :
                          (s_q.mode == 3'(MODE_TX)) & events_i.transmit_ready;
          end
        end
        1: begin
          if (s_q.packet) begin
            case (code)
              2'h0:    s_d.pins[p] = s_q.level;
              2'h1:    s_d.pins[p] = q_empty;
              2'h2:    s_d.pins[p] = q_full;
              default: s_d.pins[p] = 1'b0;
            endcase
          end else if (code == 2'h0) begin
            s_d.pins[p] = (in_rx || s_q.mode == 3'(MODE_TX)) & bit_clk_s;
          end
        end
        2: begin
          if (!s_q.packet) begin
            s_d.pins[p] = (in_rx || s_q.mode == 3'(MODE_TX)) & bit_dat_s;
          end
        end
        5: begin
          if (code == 2'h0) begin
            s_d.pins[p] = events_i.reference_clock
                        & ((s_q.mode != 3'(MODE_SLEEP)) | s_q.rc_on);
          end else if (code == 2'h3) begin
            s_d.pins[p] = (s_q.mode != 3'(MODE_SLEEP)) & events_i.mode_settled;
          end
        end
        default: s_d.pins[p] = 1'b0;
      endcase
    end

    // pattern bytes of zero are the host's to avoid; nothing checks them here
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // single synchronous reset; every field takes a constant
  // the window counter starts at zero, so a stale window can never match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.pat_lo    <= RST_PATTERN_LO;
      s_q.pat_hi    <= RST_PATTERN_HI;
      s_q.threshold <= RST_THRESHOLD;
      s_q.length    <= RST_LENGTH;
      s_q.mode      <= 3'(MODE_STANDBY);
      s_q.prev_mode <= 3'(MODE_STANDBY);
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  // bit_sync_on_o follows the mode register one cycle late
  assign dat_o         = s_q.rdata;
  assign ack_o         = s_q.ack;
  assign irq_o         = s_q.irq;
  assign general_io_o  = s_q.pins;
  assign bit_sync_on_o = s_q.bitsync_out;

endmodule

//--- tb/spr_bit_src.sv
/* spr_bit_src: pin-side source of the demodulated bit stream.
   assumes: the bench pulses start_i for one cycle while busy_o is low. */
`timescale 1ns/1ps
module spr_bit_src #(
  parameter int GAP = 4
) (
  // clock and request
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [63:0] word_i,
  input  wire logic [6:0]  nbits_i,
  // stream
  output logic             bit_data_o  = 1'b0,
  output logic             bit_valid_o = 1'b0,
  output logic             bit_clock_o,
  output logic             busy_o      = 1'b0
);
  assign bit_clock_o = bit_valid_o;
  // earliest bit is word bit 63; released data shows the inverse so stale values never match
  always begin
    @(posedge clk_i);
    if (start_i) begin
      busy_o <= 1'b1;
      for (int i = 0; i < nbits_i; i++) begin
        bit_data_o <= word_i[63-i];
        @(posedge clk_i) bit_valid_o <= 1'b1;
        repeat (GAP) @(posedge clk_i);
        bit_valid_o <= 1'b0;
        bit_data_o  <= ~word_i[63-i];
        repeat (GAP) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule

//--- tb/spr_props.sv
/* spr_props: port checker for spr_top.
   assumes: bound to spr_top in the bench top file. */
`timescale 1ns/1ps
module spr_props
  import spr_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // bus
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [7:0]           adr_i,
  input wire logic [3:0]           sel_i,
  input wire logic [31:0]          dat_i,
  input wire logic [31:0]          dat_o,
  input wire logic                 ack_o,
  input wire logic                 irq_o,
  // pins
  input wire logic [PIN_COUNT-1:0] general_io_o,
  input wire logic                 bit_sync_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_take;
  logic wr_mode;
  logic wr_mask;
  // a write is taken while ack is still low
  assign wr_take = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  assign wr_mode = wr_take && adr_i == ADDR_CHIP_MODE;
  assign wr_mask = wr_take && adr_i == ADDR_IRQ_MASK;
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_ack)
    else $error("ack missing or longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_quiet_reset: assert property ($fell(rst_i) |-> !ack_o && !irq_o && general_io_o == 6'h0)
    else $error("outputs not quiet after reset");
  a_bitsync_packet: assert property (wr_mode && dat_i[3] |-> ##[1:3] bit_sync_on_o)
    else $error("bit synchronizer not forced on in packet mode");
  a_bitsync_off: assert property (wr_mode && dat_i[4:3] == 2'h0 |-> ##[2:3] !bit_sync_on_o)
    else $error("bit synchronizer on without cause");
  a_pin0_leave_rx: assert property (wr_mode && dat_i[2:0] == MODE_STANDBY && !dat_i[3]
    |-> ##[2:4] !general_io_o[0])
    else $error("pattern hit still shown after leaving receive");
  a_pin5_sleep: assert property (wr_mode && dat_i[2:0] == MODE_SLEEP && !dat_i[5]
    |-> ##[2:4] !general_io_o[5])
    else $error("pin 5 active in sleep without rc oscillator");
  a_irq_masked: assert property (wr_mask && dat_i[3:0] == 4'h0 |-> ##[2:3] !irq_o)
    else $error("interrupt high with all sources masked");
endmodule

//--- tb/spr_top_tb.sv
/* spr_top_tb: register-level bench for spr_top.
   assumes: spr_bit_src feeds the stream, the bench plays host and queue. */
`timescale 1ns/1ps
module spr_top_tb;
  import spr_pkg::*;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc_i = 1'b0;
  logic                 stb_i = 1'b0;
  logic                 we_i  = 1'b0;
  logic [7:0]           adr_i = 8'h00;
  logic [31:0]          dat_i = 32'h0;
  logic [31:0]          dat_o;
  logic [31:0]          rd;
  logic                 ack_o, irq_o, b_data, b_valid, b_clk, busy, bso;
  logic                 start = 1'b0;
  logic [6:0]           nbits = 7'h0;
  logic [63:0]          word  = {32'ha5c3_1e77, 32'h1122_3344}; // no zero byte
  spr_queue_op_s        qop   = '0;
  spr_events_s          ev    = '0;
  logic [PIN_COUNT-1:0] io;
  int                   mismatches = 0;
  int                   tests_run  = 0;
  int                   cycles     = 0;
  always #5 clk_i = ~clk_i;
  spr_top spr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .bit_data_i(b_data), .bit_valid_i(b_valid), .bit_clock_i(b_clk), .queue_op_i(qop),
    .events_i(ev), .general_io_o(io), .bit_sync_on_o(bso));
  spr_bit_src spr_bit_src_inst (.clk_i(clk_i), .start_i(start), .word_i(word), .nbits_i(nbits),
    .bit_data_o(b_data), .bit_valid_o(b_valid), .bit_clock_o(b_clk), .busy_o(busy));
  // ----
  // tasks
  // ----
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task pin(input int k, input logic e);
    repeat (3) @(posedge clk_i);
    check({31'h0, io[k]}, {31'h0, e});
  endtask
  task qops(input logic p, input int n);
    repeat (n) begin
      @(posedge clk_i) qop <= {p, ~p};
      @(posedge clk_i) qop <= '0;
    end
  endtask
  task send(input logic [6:0] n);
    @(posedge clk_i) nbits <= n;
    start <= 1'b1;
    @(posedge clk_i) start <= 1'b0;
    do @(posedge clk_i); while (busy);
    repeat (6) @(posedge clk_i);
  endtask
  // hang guard: the sequence needs about 1100 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdm(ADDR_PATTERN_LO, '1, RST_PATTERN_LO);
    rdm(ADDR_PATTERN_HI, '1, RST_PATTERN_HI);
    rdm(ADDR_FILL_THRESHOLD, '1, {26'h0, RST_THRESHOLD});
    rdm(ADDR_PATTERN_CONFIG, '1, {29'h0, RST_LENGTH});
    rdm(8'h40, '1, 32'h0);
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h0);
    bus(1'b1, ADDR_PATTERN_HI, word[63:32]);
    bus(1'b1, ADDR_PATTERN_LO, word[31:0]);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    bus(1'b1, ADDR_CHIP_MODE, 32'h13);
    bus(1'b1, ADDR_PATTERN_CONFIG, 32'h01);
    send(7'd16);
    rdm(ADDR_STATUS, 32'h1, 32'h0);
    bus(1'b1, ADDR_PATTERN_CONFIG, 32'h17);
    send(7'd16);
    rdm(ADDR_STATUS, 32'h1, 32'h0);
    bus(1'b1, ADDR_PATTERN_CONFIG, 32'h11);
    send(7'd16);
    rdm(ADDR_STATUS, 32'h1, 32'h1);
    pin(0, 1'b1);
    check({31'h0, irq_o}, 32'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    pin(0, 1'b1);
    check({31'h0, irq_o}, 32'h0);
    qops(1'b1, 1);
    qops(1'b0, 1);
    rdm(ADDR_STATUS, 32'h1, 32'h0);
    send(7'd16);
    rdm(ADDR_STATUS, 32'h1, 32'h1);
    bus(1'b1, ADDR_CHIP_MODE, 32'h11);
    rdm(ADDR_STATUS, 32'h1, 32'h0);
    // fill threshold and queue retention in packet mode
    bus(1'b1, ADDR_CHIP_MODE, 32'h09);
    bus(1'b1, ADDR_FILL_THRESHOLD, 32'h2);
    qops(1'b1, 3);
    rdm(ADDR_STATUS, 32'h2, 32'h2);
    bus(1'b1, ADDR_FILL_THRESHOLD, 32'h5);
    rdm(ADDR_STATUS, 32'h2, 32'h2);
    qops(1'b1, 1);
    rdm(ADDR_STATUS, 32'h2, 32'h0);
    bus(1'b1, ADDR_CHIP_MODE, 32'h0c);
    rdm(ADDR_STATUS, 32'h7f00, 32'h0400);
    bus(1'b1, ADDR_CHIP_MODE, 32'h0b);
    qops(1'b1, 60);
    rdm(ADDR_STATUS, 32'h7f08, 32'h4008);
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h8);
    pin(1, 1'b1);
    qops(1'b0, 61);
    rdm(ADDR_STATUS, 32'h7f02, 32'h0302);
    bus(1'b1, ADDR_CHIP_MODE, 32'h09);
    rdm(ADDR_STATUS, 32'h7f00, 32'h0300);
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h4);
    qops(1'b0, 3);
    pin(1, 1'b1);
    qops(1'b1, 6);
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h0);
    pin(1, 1'b1);
    // event routing on pins 0 and 5
    bus(1'b1, ADDR_CHIP_MODE, 32'h0b);
    ev.payload_ready <= 1'b1;
    pin(0, 1'b1);
    ev <= '{checksum_pass: 1'b1, default: 1'b0};
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h1);
    pin(0, 1'b1);
    bus(1'b1, ADDR_PIN_ROUTE_A, 32'h0);
    bus(1'b1, ADDR_CHIP_MODE, 32'h0c);
    ev <= '{frame_sent: 1'b1, default: 1'b0};
    pin(0, 1'b1);
    bus(1'b1, ADDR_CHIP_MODE, 32'h09);
    ev.reference_clock <= 1'b1;
    bus(1'b1, ADDR_PIN_ROUTE_B, 32'h0);
    pin(5, 1'b1);
    bus(1'b1, ADDR_PIN_ROUTE_B, 32'hc);
    pin(5, 1'b0);
    ev.mode_settled <= 1'b1;
    pin(5, 1'b1);
    bus(1'b1, ADDR_PIN_ROUTE_B, 32'h0);
    bus(1'b1, ADDR_CHIP_MODE, 32'h00);
    pin(5, 1'b0);
    bus(1'b1, ADDR_CHIP_MODE, 32'h20);
    pin(5, 1'b1);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    stop_test;
  end
endmodule

bind spr_top spr_props #(.DEPTH(DEPTH)) spr_props_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .irq_o(irq_o), .general_io_o(general_io_o), .bit_sync_on_o(bit_sync_on_o));
